// File: bench/sirm_fabric_model.sv
`timescale 1ns/100ps

module sirm_fabric_model
(
	input	wire logic	clock,
	input	wire logic	sys_rst,
	input	wire logic	go,
	input	wire logic [13:0]	desc,
	output	logic	rx_valid,
	output	logic [13:0]	rx_desc
);
	logic [13:0]	q = 14'h0;
	logic	v = 1'b0;
	// Descriptor for one cycle, scrambled while idle
	always @(posedge clock)
	begin
		v <= go & ~sys_rst;
		q <= go ? desc : ~q;
	end
	assign rx_valid = v;
	assign rx_desc = q;
endmodule

// File: bench/sirm_ingress_assertions.sv
`timescale 1ns/100ps
`include "sirm_params.svh"

module sirm_ingress_checker
#(
	parameter int NUM_PORTS = 3
)
(
	input	wire logic	clock,
	input	wire logic	sys_rst,
	input	wire logic [15:0]	reg_addr,
	input	wire logic	reg_wr,
	input	wire logic [31:0]	reg_wdata,
	input	wire logic	rx_valid,
	input	wire logic [1:0]	rx_port,
	input	wire logic [2:0]	rx_prio,
	input	logic	dec_valid,
	input	logic [2:0]	dec_fwd_map,
	input	logic	dec_drop,
	input	logic	dec_learn,
	input	logic [1:0]	dec_queue,
	input	logic	filtered_cnt_inc,
	input	logic	drop_int_set,
	input	wire logic	tx_valid,
	input	wire logic [1:0]	tx_port,
	input	logic	tx_mirror_valid,
	input	logic [2:0]	tx_mirror_map
);
	logic [15:0]	pq_q;
	logic [5:0]	ps_q;
	logic [8:0]	mr_q;
	logic [1:0]	st;
	logic [1:0]	qx;
	logic [2:0]	sn;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Shadow copies of the configuration
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			pq_q <= 16'(`SIRM_RST_PRI_QUEUE);
			ps_q <= 6'(`SIRM_RST_PORT_STATE);
			mr_q <= 9'(`SIRM_RST_PORT_MIRROR);
		end
		else if (reg_wr)
		begin
			if (reg_addr == `SIRM_ADDR_PRI_QUEUE)
				pq_q <= reg_wdata[15:0];
			if (reg_addr == `SIRM_ADDR_PORT_STATE)
				ps_q <= reg_wdata[5:0];
			if (reg_addr == `SIRM_ADDR_PORT_MIRROR)
				mr_q <= reg_wdata[8:0];
		end
	end
	// Per-packet lookups
	assign st = ps_q[{rx_port, 1'b0} +: 2];
	assign qx = pq_q[{rx_prio, 1'b0} +: 2];
	assign sn = mr_q[7:5];
	dec_follows_a: assert property (rx_valid |=> dec_valid) else $error("no decision");
	queue_map_a: assert property (rx_valid |=> dec_drop || dec_queue == $past(qx)) else $error("queue");
	drop_pulse_a: assert property (dec_valid && dec_drop |-> filtered_cnt_inc && drop_int_set)
		else $error("drop pulses");
	idle_pulse_a: assert property (!dec_valid |-> !filtered_cnt_inc && !drop_int_set)
		else $error("stray pulse");
	block_drop_a: assert property (rx_valid && rx_port < 2'h3 && st[0] |=> dec_drop && !dec_learn)
		else $error("blocked port passed");
	learn_drop_a: assert property (rx_valid && rx_port < 2'h3 && st == 2'h2 |=> dec_drop)
		else $error("learning port forwarded");
	filt_hide_a: assert property (rx_valid && !mr_q[8] |=> !dec_drop || dec_fwd_map == 3'h0)
		else $error("drop mirrored");
	tx_copy_a: assert property (tx_valid && tx_port < 2'h3 && mr_q[0] && mr_q[tx_port + 2]
		|=> tx_mirror_valid && tx_mirror_map == $past(sn)) else $error("tx copy");
	tx_quiet_a: assert property (tx_valid && !mr_q[0] |=> !tx_mirror_valid) else $error("tx copy off");
endmodule

bind sirm_ingress sirm_ingress_checker #(.NUM_PORTS(NUM_PORTS)) u_chk
(
	.clock            (clock),
	.sys_rst          (sys_rst),
	.reg_addr         (reg_addr),
	.reg_wr           (reg_wr),
	.reg_wdata        (reg_wdata),
	.rx_valid         (rx_valid),
	.rx_port          (rx_port),
	.rx_prio          (rx_prio),
	.dec_valid        (dec_valid),
	.dec_fwd_map      (dec_fwd_map),
	.dec_drop         (dec_drop),
	.dec_learn        (dec_learn),
	.dec_queue        (dec_queue),
	.filtered_cnt_inc (filtered_cnt_inc),
	.drop_int_set     (drop_int_set),
	.tx_valid         (tx_valid),
	.tx_port          (tx_port),
	.tx_mirror_valid  (tx_mirror_valid),
	.tx_mirror_map    (tx_mirror_map)
);

// File: bench/tb.sv
`timescale 1ns/100ps
`include "sirm_params.svh"
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("FAIL %0t %s", $time, m); end end

module tb;
	logic	clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, go = 0, tx_valid = 0;
	logic	rx_valid, dec_valid, dec_drop, dec_learn, f_inc, d_int, tx_mv;
	logic [15:0]	reg_addr = 16'h0, pq = 16'hfa41;
	logic [31:0]	reg_wdata = 32'h0, reg_rdata;
	logic [13:0]	desc = 14'h0, rd_q;
	logic [1:0]	tx_port = 2'h0, dec_queue;
	logic [2:0]	dec_fwd_map, tx_mm;
	int	n_fail = 0, n_checks = 0;
	always #12.5 clock = ~clock;
	sirm_fabric_model mac (.clock(clock), .sys_rst(sys_rst), .go(go), .desc(desc),
		.rx_valid(rx_valid), .rx_desc(rd_q));
	sirm_ingress dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_port(rd_q[13:12]),
		.rx_vid_tagged(rd_q[11]), .rx_prio(rd_q[10:8]), .rx_vlan_member(rd_q[7:5]), .rx_vlan_active(rd_q[4]),
		.rx_da_found(rd_q[3]), .rx_da_map(rd_q[2:0]), .dec_valid(dec_valid), .dec_fwd_map(dec_fwd_map),
		.dec_drop(dec_drop), .dec_learn(dec_learn), .dec_queue(dec_queue), .filtered_cnt_inc(f_inc),
		.drop_int_set(d_int), .tx_valid(tx_valid), .tx_port(tx_port), .tx_mirror_valid(tx_mv), .tx_mirror_map(tx_mm));
	// Register access
	task wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [31:0] e);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		@(negedge clock);
		`CHK(reg_rdata, e, "read")
	endtask
	function automatic logic [13:0] dsc(logic [1:0] p, logic t, logic [2:0] m, logic a, f, logic [2:0] dm);
		return {p, t, 3'h0, m, a, f, dm};
	endfunction
	// One packet and its decision
	task pkt(input logic [13:0] d, input logic [2:0] fwd, input logic drp, lrn);
		@(negedge clock);
		desc = d;
		go = 1'b1;
		@(negedge clock);
		go = 1'b0;
		// Model pulse lands one edge later, decision stands the cycle after
		@(negedge clock);
		`CHK(dec_valid, 1'b1, "valid")
		`CHK(dec_drop, drp, "drop")
		`CHK(({f_inc, d_int}), ({drp, drp}), "pulses")
		`CHK(dec_learn, lrn, "learn")
		`CHK(dec_fwd_map, fwd, "fwd map")
		`CHK(dec_queue, (pq[{d[10:8], 1'b0} +: 2]), "queue")
	endtask
	task txp(input logic [1:0] p, input logic v, input logic [2:0] m);
		@(negedge clock);
		tx_port = p;
		tx_valid = 1'b1;
		@(negedge clock);
		tx_valid = 1'b0;
		tx_port = ~p;
		`CHK(tx_mv, v, "tx copy")
		if (v)
			`CHK(tx_mm, m, "sniffer")
	endtask
	task s_regs;
		rd(`SIRM_ADDR_PORT_INGRESS, 32'h38);
		rd(`SIRM_ADDR_PRI_QUEUE, 32'hfa41);
		rd(`SIRM_ADDR_GLOBAL_INGRESS, 32'h0);
		wr(`SIRM_ADDR_PORT_STATE, 32'hffff_ffe4);
		rd(`SIRM_ADDR_PORT_STATE, 32'h24);
		rd(16'h1844, 32'h0);
	endtask
	task s_stp;
		wr(`SIRM_ADDR_PORT_STATE, 32'h39);
		pkt(dsc(0, 1, 7, 1, 0, 0), 0, 1, 0);
		pkt(dsc(1, 1, 7, 1, 0, 0), 0, 1, 1);
		pkt(dsc(2, 1, 7, 1, 0, 0), 0, 1, 0);
		wr(`SIRM_ADDR_PORT_STATE, 32'h0);
		wr(`SIRM_ADDR_PORT_INGRESS, 32'h30);
		pkt(dsc(0, 1, 7, 1, 0, 0), 3'h6, 0, 0);
		pkt(dsc(1, 1, 7, 1, 0, 0), 3'h5, 0, 1);
	endtask
	task s_vlan;
		wr(`SIRM_ADDR_PORT_INGRESS, 32'h39);
		pkt(dsc(0, 1, 6, 1, 0, 0), 3'h6, 0, 1);
		wr(`SIRM_ADDR_GLOBAL_INGRESS, 32'h1);
		pkt(dsc(0, 1, 6, 1, 0, 0), 0, 1, 1);
		wr(`SIRM_ADDR_NON_MEMBER, 32'h1);
		pkt(dsc(0, 1, 6, 1, 0, 0), 3'h6, 0, 1);
		pkt(dsc(0, 1, 6, 0, 0, 0), 0, 1, 1);
		pkt(dsc(0, 1, 3, 1, 1, 4), 0, 1, 1);
		pkt(dsc(0, 1, 5, 1, 1, 4), 3'h4, 0, 1);
		wr(`SIRM_ADDR_TAGGED_ONLY, 32'h2);
		pkt(dsc(1, 0, 7, 1, 0, 0), 0, 1, 1);
		wr(`SIRM_ADDR_GLOBAL_INGRESS, 32'h0);
		pkt(dsc(1, 0, 7, 1, 0, 0), 3'h5, 0, 1);
	endtask
	task s_queue;
		for (int j = 0; j < 2; j++)
		begin
			for (int p = 0; p < 8; p++)
				pkt({2'h0, 1'b1, 3'(p), 3'h7, 2'h2, 3'h0}, 3'h6, 0, 1);
			pq = 16'h1be4;
			wr(`SIRM_ADDR_PRI_QUEUE, 32'h1be4);
		end
	endtask
	task s_mirror;
		txp(2, 0, 0);
		wr(`SIRM_ADDR_PORT_MIRROR, 32'h57); // single sniffer
		pkt(dsc(0, 1, 7, 1, 1, 4), 3'h6, 0, 1);
		pkt(dsc(1, 1, 7, 1, 0, 0), 3'h5, 0, 1);
		txp(2, 1, 3'h2);
		txp(1, 0, 0);
		wr(`SIRM_ADDR_PORT_STATE, 32'h1);
		pkt(dsc(0, 1, 7, 1, 0, 0), 0, 1, 0);
		wr(`SIRM_ADDR_PORT_MIRROR, 32'h157);
		pkt(dsc(0, 1, 7, 1, 0, 0), 3'h2, 1, 0);
		txp(0, 1, 3'h2);
	endtask
	task s_reset;
		sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		rd(`SIRM_ADDR_PORT_MIRROR, 32'h0);
	endtask
	task results;
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(negedge clock);
		sys_rst = 1'b0;
		s_regs;
		s_stp;
		s_vlan;
		s_queue;
		s_mirror;
		s_reset;
		results;
	end
	initial
	begin
		#1000000;
		n_fail++;
		results;
	end
endmodule

// File: design/sirm_cfg_if.sv
`timescale 1ns/100ps
`include "sirm_params.svh"

interface sirm_cfg_if;
	logic                             vlan_en;
	logic [2:0]                       learn_en;
	logic [2:0]                       member_chk;
	logic [2:0]                       tagged_only;
	logic [2:0]                       admit_nm;
	logic [`SIRM_PORT_STATE_W-1:0]    port_state;
	logic [`SIRM_PRI_MAP_W-1:0]       pri_map;
	logic [`SIRM_MIRROR_W-1:0]        mirror;

	modport regs
	(
		output vlan_en, learn_en, member_chk, tagged_only, admit_nm, port_state, pri_map, mirror
	);
	modport core
	(
		input vlan_en, learn_en, member_chk, tagged_only, admit_nm, port_state, pri_map, mirror
	);
endinterface

// File: design/sirm_ingress.sv
`timescale 1ns/100ps
`include "sirm_params.svh"

module sirm_ingress
	import sirm_pkg::*;
#(
	parameter int NUM_PORTS = 3
)
(
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic [15:0]   reg_addr,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	input  wire logic [31:0]   reg_wdata,
	output logic      [31:0]   reg_rdata,
	input  wire logic          rx_valid,
	input  wire logic [1:0]    rx_port,
	input  wire logic          rx_vid_tagged,
	input  wire logic [2:0]    rx_prio,
	input  wire logic [2:0]    rx_vlan_member,
	input  wire logic          rx_vlan_active,
	input  wire logic          rx_da_found,
	input  wire logic [2:0]    rx_da_map,
	output logic               dec_valid,
	output logic      [2:0]    dec_fwd_map,
	output logic               dec_drop,
	output logic               dec_learn,
	output logic      [1:0]    dec_queue,
	output logic               filtered_cnt_inc,
	output logic               drop_int_set,
	input  wire logic          tx_valid,
	input  wire logic [1:0]    tx_port,
	output logic               tx_mirror_valid,
	output logic      [2:0]    tx_mirror_map
);

	// ----------------------------------------
	// Configuration checks
	// ----------------------------------------
	// Register layout fixes three ports
	if (NUM_PORTS != 3)
		$error("sirm_ingress supports exactly three ports");

	// Field layout must fit the configuration words
	if (`SIRM_MIR_FILT_BIT >= `SIRM_MIRROR_W || 2 * NUM_PORTS > `SIRM_PORT_STATE_W)
		$error("sirm_ingress field layout does not fit the registers");

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Configuration bundle from the register file
	sirm_cfg_if cfg ();

	// Register decode, storage and read-back
	sirm_regs u_regs
	(
		.clock     (clock),
		.sys_rst   (sys_rst),
		.reg_addr  (reg_addr),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_wdata (reg_wdata),
		.reg_rdata (reg_rdata),
		.cfg       (cfg.regs)
	);

	// ----------------------------------------
	// Mirror configuration fields
	// ----------------------------------------
	sirm_pmap_t  sniffer;
	sirm_pmap_t  mirrored;
	logic        rx_mir_en;
	logic        tx_mir_en;
	logic        filt_mir_en;

	// Mirror control bits
	assign sniffer     = cfg.mirror[`SIRM_SNIFFER_LSB +: 3];
	assign mirrored    = cfg.mirror[`SIRM_MIRRORED_LSB +: 3];
	assign rx_mir_en   = cfg.mirror[`SIRM_RXMIR_BIT];
	assign tx_mir_en   = cfg.mirror[`SIRM_TXMIR_BIT];
	assign filt_mir_en = cfg.mirror[`SIRM_MIR_FILT_BIT];

	// ----------------------------------------
	// Receive decision, live config per packet
	// ----------------------------------------
	sirm_pmap_t  pbit;
	sirm_stp_t   st;
	logic        port_ok;
	logic        chk;
	logic        ingress_fail;
	logic        egress_fail;
	logic        tag_fail;
	logic        stp_fwd;
	logic        stp_learn;
	logic        mir;
	sirm_pmap_t  egress;
	logic        drop_d;
	logic        learn_d;
	logic [2:0]  fwd_d;
	logic [1:0]  queue_d;

	// Two-bit entry of a packed per-index table
	function automatic logic [1:0] pair_sel(input logic [15:0] tbl, input logic [2:0] idx);
		logic [1:0] f;
		f = tbl[{idx, 1'b0} +: 2];
		return f;
	endfunction

	// Ingress port and its spanning-tree state
	always_comb
	begin
		pbit    = sirm_port_bit(rx_port);
		port_ok = |pbit;
		st      = SIRM_ST_DIS;
		if (port_ok)
			st = sirm_stp_t'(pair_sel({10'h000, cfg.port_state}, {1'b0, rx_port}));
		stp_fwd   = (st == SIRM_ST_FWD);
		stp_learn = (st == SIRM_ST_FWD) || (st == SIRM_ST_LEARN);
	end

	// VLAN filters, all gated by the global enable
	always_comb
	begin
		chk          = cfg.vlan_en & |(cfg.member_chk & pbit);
		ingress_fail = chk & ~|(rx_vlan_member & pbit)
			& ~(|(cfg.admit_nm & pbit) & rx_vlan_active);
		egress_fail  = chk & rx_da_found & |(rx_da_map & ~rx_vlan_member);
		tag_fail     = cfg.vlan_en & |(cfg.tagged_only & pbit) & ~rx_vid_tagged;
	end

	// Drop and learn verdicts, learning ignores VLAN drops
	always_comb
	begin
		drop_d  = ~port_ok | ~stp_fwd | ingress_fail | egress_fail | tag_fail;
		learn_d = port_ok & stp_learn & |(cfg.learn_en & pbit);
	end

	// Egress map plus sniffer copy, known destination to its port, unknown floods
	always_comb
	begin
		egress = (rx_da_found ? rx_da_map : 3'h7) & ~pbit;
		mir    = rx_mir_en & |(mirrored & pbit);
		if (drop_d)
			fwd_d = (mir & filt_mir_en) ? sniffer : 3'h0;
		else
			fwd_d = egress | (mir ? sniffer : 3'h0);
	end

	// Traffic class lookup
	always_comb
	begin
		queue_d = pair_sel(cfg.pri_map, rx_prio);
	end

	// Registered decision, one cycle after request
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			dec_valid        <= 1'b0;
			dec_fwd_map      <= 3'h0;
			dec_drop         <= 1'b0;
			dec_learn        <= 1'b0;
			dec_queue        <= 2'h0;
			filtered_cnt_inc <= 1'b0;
			drop_int_set     <= 1'b0;
		end
		else
		begin
			dec_valid        <= rx_valid;
			filtered_cnt_inc <= rx_valid & drop_d;
			drop_int_set     <= rx_valid & drop_d;
			if (rx_valid)
			begin
				dec_fwd_map <= fwd_d;
				dec_drop    <= drop_d;
				dec_learn   <= learn_d;
				dec_queue   <= queue_d;
			end
		end
	end

	// ----------------------------------------
	// Transmit mirroring
	// ----------------------------------------
	logic        tx_hit;

	// Transmitted on a mirrored port with copies on
	assign tx_hit = tx_valid & tx_mir_en & |(mirrored & sirm_port_bit(tx_port));

	// Copy pulse and sniffer map
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			tx_mirror_valid <= 1'b0;
			tx_mirror_map   <= 3'h0;
		end
		else
		begin
			tx_mirror_valid <= tx_hit;
			if (tx_valid)
				tx_mirror_map <= sniffer;
		end
	end

endmodule

// File: design/sirm_params.svh
`ifndef SIRM_PARAMS_SVH
`define SIRM_PARAMS_SVH

// ----------------------------------------
// Register numbers
// ----------------------------------------
`define SIRM_ADDR_GLOBAL_INGRESS   16'h1840
`define SIRM_ADDR_PORT_INGRESS     16'h1841
`define SIRM_ADDR_TAGGED_ONLY      16'h1842
`define SIRM_ADDR_PORT_STATE       16'h1843
`define SIRM_ADDR_PRI_QUEUE        16'h1845
`define SIRM_ADDR_PORT_MIRROR      16'h1846
`define SIRM_ADDR_NON_MEMBER       16'h1849

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SIRM_RST_GLOBAL_INGRESS    32'h0000_0000
`define SIRM_RST_PORT_INGRESS      32'h0000_0038
`define SIRM_RST_TAGGED_ONLY       32'h0000_0000
`define SIRM_RST_PORT_STATE        32'h0000_0000
`define SIRM_RST_PRI_QUEUE         32'h0000_fa41
`define SIRM_RST_PORT_MIRROR       32'h0000_0000
`define SIRM_RST_NON_MEMBER        32'h0000_0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SIRM_VLAN_EN_BIT           0
`define SIRM_LEARN_LSB             3
`define SIRM_MEMBER_CHK_LSB        0
`define SIRM_TXMIR_BIT             0
`define SIRM_RXMIR_BIT             1
`define SIRM_MIRRORED_LSB          2
`define SIRM_SNIFFER_LSB           5
`define SIRM_MIR_FILT_BIT          8
`define SIRM_PORT_STATE_W          6
`define SIRM_PRI_MAP_W             16
`define SIRM_MIRROR_W              9

`endif

// File: design/sirm_pkg.sv
package sirm_pkg;

	// Spanning-tree port state encoding
	typedef enum logic [1:0]
	{
		SIRM_ST_FWD   = 2'h0,
		SIRM_ST_BLOCK = 2'h1,
		SIRM_ST_LEARN = 2'h2,
		SIRM_ST_DIS   = 2'h3
	} sirm_stp_t;

	typedef logic [2:0] sirm_pmap_t;

	// Port number to one-hot map, zero for an illegal number
	function automatic sirm_pmap_t sirm_port_bit(input logic [1:0] port);
		sirm_pmap_t m;
		m = 3'h0;
		if (port < 2'h3)
			m[port] = 1'b1;
		return m;
	endfunction

endpackage

// File: design/sirm_regs.sv
`timescale 1ns/100ps
`include "sirm_params.svh"

module sirm_regs
	import sirm_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic [15:0]   reg_addr,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	input  wire logic [31:0]   reg_wdata,
	output logic      [31:0]   reg_rdata,
	sirm_cfg_if.regs           cfg
);

	logic [31:0] glob_q;
	logic [31:0] ping_q;
	logic [31:0] tonly_q;
	logic [31:0] state_q;
	logic [31:0] pri_q;
	logic [31:0] mir_q;
	logic [31:0] nmem_q;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;

	// ----------------------------------------
	// Register writes, implemented bits only
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			glob_q  <= `SIRM_RST_GLOBAL_INGRESS;
			ping_q  <= `SIRM_RST_PORT_INGRESS;
			tonly_q <= `SIRM_RST_TAGGED_ONLY;
			state_q <= `SIRM_RST_PORT_STATE;
			pri_q   <= `SIRM_RST_PRI_QUEUE;
			mir_q   <= `SIRM_RST_PORT_MIRROR;
			nmem_q  <= `SIRM_RST_NON_MEMBER;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`SIRM_ADDR_GLOBAL_INGRESS: glob_q  <= reg_wdata & 32'h0000_0001;
				`SIRM_ADDR_PORT_INGRESS:   ping_q  <= reg_wdata & 32'h0000_003f;
				`SIRM_ADDR_TAGGED_ONLY:    tonly_q <= reg_wdata & 32'h0000_0007;
				`SIRM_ADDR_PORT_STATE:     state_q <= reg_wdata & 32'h0000_003f;
				`SIRM_ADDR_PRI_QUEUE:      pri_q   <= reg_wdata & 32'h0000_ffff;
				`SIRM_ADDR_PORT_MIRROR:    mir_q   <= reg_wdata & 32'h0000_01ff;
				`SIRM_ADDR_NON_MEMBER:     nmem_q  <= reg_wdata & 32'h0000_0007;
				default:                   ;
			endcase
		end
	end

	// Read mux, unmapped numbers read zero
	always_comb
	begin
		case (reg_addr)
			`SIRM_ADDR_GLOBAL_INGRESS: rdata_d = glob_q;
			`SIRM_ADDR_PORT_INGRESS:   rdata_d = ping_q;
			`SIRM_ADDR_TAGGED_ONLY:    rdata_d = tonly_q;
			`SIRM_ADDR_PORT_STATE:     rdata_d = state_q;
			`SIRM_ADDR_PRI_QUEUE:      rdata_d = pri_q;
			`SIRM_ADDR_PORT_MIRROR:    rdata_d = mir_q;
			`SIRM_ADDR_NON_MEMBER:     rdata_d = nmem_q;
			default:                   rdata_d = 32'h0000_0000;
		endcase
	end

	// Read data held until next read
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			rdata_q <= 32'h0000_0000;
		else if (reg_rd)
			rdata_q <= rdata_d;
	end

	assign reg_rdata       = rdata_q;
	assign cfg.vlan_en     = glob_q[`SIRM_VLAN_EN_BIT];
	assign cfg.learn_en    = ping_q[`SIRM_LEARN_LSB +: 3];
	assign cfg.member_chk  = ping_q[`SIRM_MEMBER_CHK_LSB +: 3];
	assign cfg.tagged_only = tonly_q[2:0];
	assign cfg.admit_nm    = nmem_q[2:0];
	assign cfg.port_state  = state_q[`SIRM_PORT_STATE_W-1:0];
	assign cfg.pri_map     = pri_q[`SIRM_PRI_MAP_W-1:0];
	assign cfg.mirror      = mir_q[`SIRM_MIRROR_W-1:0];

endmodule
